// ### nvmc_regs.svh
// offsets, bit positions, reset values and timing counts of the nvm controller
`ifndef NVMC_REGS_SVH
`define NVMC_REGS_SVH
// device registers in i/o space
`define NVMC_IO_CTRL     6'h1F
`define NVMC_IO_DATA     6'h20
`define NVMC_IO_ADDR     6'h21
// nvm_control_reg bit positions
`define NVMC_B_RSTRB     0
`define NVMC_B_GO        1
`define NVMC_B_ARM       2
`define NVMC_B_RIE       3
`define NVMC_B_MODE_LO   4
`define NVMC_B_MODE_HI   5
// reset and erased values
`define NVMC_DATA_RST    8'h00
`define NVMC_ADDR_RST    8'h00
`define NVMC_ERASED      8'hFF
// cycle counts on the cpu clock
`define NVMC_ARM_CYCLES  3'h4
`define NVMC_RD_HALT     3'h4
`define NVMC_PG_HALT     3'h2
// rates in khz and programming times in us
`define NVMC_CLK_KHZ     40000
`define NVMC_OSC_KHZ     8000
`define NVMC_ATOMIC_US   3400
`define NVMC_SPLIT_US    1800
// host wishbone register indices, byte address is four times the index
`define NVMC_WB_ADDR     3'h0
`define NVMC_WB_WDATA    3'h1
`define NVMC_WB_CFG      3'h2
`define NVMC_WB_CMD      3'h3
`define NVMC_WB_RDATA    3'h4
// host command and config bits
`define NVMC_C_READ      0
`define NVMC_C_PROG      1
`define NVMC_CFG_SPCHK   3
`endif

// ### nvmc_pkg.sv
// types shared by both ends of the nvm controller
package nvmc_pkg;
    typedef enum logic [1:0] {
        NVMC_MODE_ATOMIC,
        NVMC_MODE_ERASE,
        NVMC_MODE_WRITE,
        NVMC_MODE_RSVD
    } nvmc_mode_e;

    typedef enum logic [3:0] {
        NVMC_H_IDLE,
        NVMC_H_POLL,
        NVMC_H_CHK,
        NVMC_H_MODE,
        NVMC_H_ADDR,
        NVMC_H_DATA,
        NVMC_H_ARM,
        NVMC_H_GO,
        NVMC_H_STROBE,
        NVMC_H_FETCH,
        NVMC_H_TAKE,
        NVMC_H_GAP,
        NVMC_H_HOLD
    } nvmc_hst_e;
endpackage

// ### nvmc_link_if.sv
// i/o register link between the cpu side and the nvm controller
`timescale 1ns/1ps
interface nvmc_link_if;
    logic [5:0] io_addr;
    logic [7:0] io_wdata;
    logic       io_we;
    logic       io_re;
    logic [7:0] io_rdata;
    logic       halt;
    logic       irq;

    modport dev (
        input  io_addr,
        input  io_wdata,
        input  io_we,
        input  io_re,
        output io_rdata,
        output halt,
        output irq
    );

    modport cpu (
        output io_addr,
        output io_wdata,
        output io_we,
        output io_re,
        input  io_rdata,
        input  halt,
        input  irq
    );
endinterface

// ### nvmc_device.sv
// nvm controller: 256 byte data store with read, erase and write through i/o registers
`timescale 1ns/1ps
`include "nvmc_regs.svh"

module nvmc_device
    import nvmc_pkg::*;
#(
    parameter int ATOMIC_TICKS = `NVMC_ATOMIC_US * (`NVMC_OSC_KHZ / 1000),
    parameter int SPLIT_TICKS  = `NVMC_SPLIT_US * (`NVMC_OSC_KHZ / 1000)
) (
    // clock and resets
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  por_i,
    // i/o register link
    nvmc_link_if.dev   link
);
    localparam int    DIV = `NVMC_CLK_KHZ / `NVMC_OSC_KHZ;
    localparam logic [2:0] DIV_LAST = 3'(DIV - 1);

    logic [7:0]  mem [256];
    logic [7:0]  addr_q;
    logic [7:0]  data_q;
    logic [7:0]  rdata_q;
    nvmc_mode_e  mode_q;
    nvmc_mode_e  op_mode_q;
    logic [7:0]  op_addr_q;
    logic [7:0]  op_data_q;
    logic        rie_q;
    logic        busy_q;
    logic [2:0]  arm_cnt_q;
    logic [2:0]  halt_cnt_q;
    logic [2:0]  div_q;
    logic [15:0] prog_cnt_q;
    logic        tick;
    logic        wr_ctrl;
    logic        wr_data;
    logic        wr_addr;
    logic        start;
    logic        rd_go;
    logic        done;
    logic        any_rst;
    nvmc_mode_e  wr_mode;

    assign any_rst = rst_i | por_i;
    assign wr_ctrl = link.io_we && (link.io_addr == `NVMC_IO_CTRL);
    assign wr_data = link.io_we && (link.io_addr == `NVMC_IO_DATA);
    assign wr_addr = link.io_we && (link.io_addr == `NVMC_IO_ADDR);
    assign wr_mode = nvmc_mode_e'({link.io_wdata[`NVMC_B_MODE_HI], link.io_wdata[`NVMC_B_MODE_LO]});

    // go is honoured only while the arm window is open and nothing runs
    assign start = wr_ctrl && link.io_wdata[`NVMC_B_GO] && (arm_cnt_q != 3'h0)
                   && !busy_q && (mode_q != NVMC_MODE_RSVD);
    assign rd_go = wr_ctrl && link.io_wdata[`NVMC_B_RSTRB] && !busy_q;

    // stands in for the 8 MHz oscillator; only por stops it so a running program keeps time
    assign tick = (div_q == DIV_LAST);
    always_ff @(posedge clk_i) begin
        if (por_i || tick) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_q + 3'h1;
        end
    end

    // programming timer counts oscillator ticks
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            prog_cnt_q <= 16'h0000;
        end else if (start) begin
            if (mode_q == NVMC_MODE_ATOMIC) begin
                prog_cnt_q <= 16'(ATOMIC_TICKS);
            end else begin
                prog_cnt_q <= 16'(SPLIT_TICKS);
            end
        end else if (busy_q && tick && prog_cnt_q != 16'h0000) begin
            prog_cnt_q <= prog_cnt_q - 16'h0001;
        end
    end

    assign done = busy_q && tick && (prog_cnt_q == 16'h0001);

    // busy is the go bit; plain reset leaves it alone
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            busy_q <= 1'b0;
        end else if (start) begin
            busy_q <= 1'b1;
        end else if (done) begin
            busy_q <= 1'b0;
        end
    end

    // target is captured at start so later register traffic cannot disturb it
    always_ff @(posedge clk_i) begin
        if (start) begin
            op_mode_q <= mode_q;
            op_addr_q <= addr_q;
            op_data_q <= data_q;
        end
    end

    // the array holds no reset, it is the non-volatile store
    always_ff @(posedge clk_i) begin
        if (done) begin
            unique case (op_mode_q)
                NVMC_MODE_ATOMIC: mem[op_addr_q] <= op_data_q;
                NVMC_MODE_ERASE:  mem[op_addr_q] <= `NVMC_ERASED;
                // write only can clear bits but never set them
                NVMC_MODE_WRITE:  mem[op_addr_q] <= mem[op_addr_q] & op_data_q;
                NVMC_MODE_RSVD:   mem[op_addr_q] <= mem[op_addr_q];
            endcase
        end
    end

    // mode field
    always_ff @(posedge clk_i) begin
        if (por_i || (rst_i && !busy_q)) begin
            mode_q <= NVMC_MODE_ATOMIC;
        end else if (wr_ctrl && !busy_q) begin
            mode_q <= wr_mode;
        end
    end

    // interrupt enable
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            rie_q <= 1'b0;
        end else if (wr_ctrl) begin
            rie_q <= link.io_wdata[`NVMC_B_RIE];
        end
    end

    // arm window, closed by hardware four cycles after it opens
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            arm_cnt_q <= 3'h0;
        end else if (wr_ctrl && link.io_wdata[`NVMC_B_ARM] && arm_cnt_q == 3'h0) begin
            arm_cnt_q <= `NVMC_ARM_CYCLES;
        end else if (start) begin
            arm_cnt_q <= 3'h0;
        end else if (arm_cnt_q != 3'h0) begin
            arm_cnt_q <= arm_cnt_q - 3'h1;
        end
    end

    // cpu halt after a read strobe or a program start
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            halt_cnt_q <= 3'h0;
        end else if (rd_go) begin
            halt_cnt_q <= `NVMC_RD_HALT;
        end else if (start) begin
            halt_cnt_q <= `NVMC_PG_HALT;
        end else if (halt_cnt_q != 3'h0) begin
            halt_cnt_q <= halt_cnt_q - 3'h1;
        end
    end

    // address register
    always_ff @(posedge clk_i) begin
        if (any_rst && !busy_q) begin
            addr_q <= `NVMC_ADDR_RST;
        end else if (wr_addr && !busy_q) begin
            addr_q <= link.io_wdata;
        end
    end

    // data register, loaded by software or by a read strobe
    always_ff @(posedge clk_i) begin
        if (any_rst && !busy_q) begin
            data_q <= `NVMC_DATA_RST;
        end else if (rd_go) begin
            data_q <= mem[addr_q];
        end else if (wr_data && !busy_q) begin
            data_q <= link.io_wdata;
        end
    end

    // register read port, answer one cycle after the read request
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            rdata_q <= 8'h00;
        end else if (link.io_re) begin
            unique case (link.io_addr)
                `NVMC_IO_CTRL: rdata_q <= {2'b00, mode_q, rie_q, (arm_cnt_q != 3'h0), busy_q, 1'b0};
                `NVMC_IO_DATA: rdata_q <= data_q;
                `NVMC_IO_ADDR: rdata_q <= addr_q;
                default:       rdata_q <= 8'h00;
            endcase
        end
    end

    assign link.io_rdata = rdata_q;
    assign link.halt     = (halt_cnt_q != 3'h0);
    assign link.irq      = rie_q && !busy_q;

endmodule // nvmc_device

// ### nvmc_host.sv
// cpu-side sequencer: wishbone slave that runs read and program sequences on the link
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "nvmc_regs.svh"

module nvmc_host
    import nvmc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // flash self-programming status, same clock
    input  wire logic        selfprog_active_i,
    // i/o register link
    nvmc_link_if.cpu         link
);
    nvmc_hst_e   state_q;
    nvmc_hst_e   ret_q;
    logic        ack_q;
    logic        op_rd_q;
    logic [7:0]  tgt_addr_q;
    logic [7:0]  tgt_data_q;
    logic [7:0]  rd_data_q;
    logic [1:0]  mode_q;
    logic        rie_q;
    logic        sp_chk_q;
    logic [5:0]  io_addr_q;
    logic [7:0]  io_wdata_q;
    logic        io_we_q;
    logic        io_re_q;
    logic        wr_en;
    logic        idle;
    logic [2:0]  idx;
    logic [7:0]  ctrl_base;

    assign idx       = wb_adr_i[4:2];
    assign idle      = (state_q == NVMC_H_IDLE);
    assign wr_en     = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
    assign ctrl_base = {2'b00, mode_q, rie_q, 3'b000};

    // every request is answered one cycle after it is raised
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
            unique case (idx)
                `NVMC_WB_ADDR:  wb_dat_o <= {24'h00_0000, tgt_addr_q};
                `NVMC_WB_WDATA: wb_dat_o <= {24'h00_0000, tgt_data_q};
                `NVMC_WB_CFG:   wb_dat_o <= {28'h000_0000, sp_chk_q, rie_q, mode_q};
                `NVMC_WB_CMD:   wb_dat_o <= {29'h0000_0000, link.halt, link.irq, !idle};
                `NVMC_WB_RDATA: wb_dat_o <= {24'h00_0000, rd_data_q};
                default:        wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // order registers are frozen while a sequence runs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tgt_addr_q <= 8'h00;
            tgt_data_q <= 8'h00;
            mode_q     <= 2'b00;
            rie_q      <= 1'b0;
            sp_chk_q   <= 1'b0;
        end else if (wr_en && idle) begin
            if (idx == `NVMC_WB_ADDR) begin
                tgt_addr_q <= wb_dat_i[7:0];
            end
            if (idx == `NVMC_WB_WDATA) begin
                tgt_data_q <= wb_dat_i[7:0];
            end
            if (idx == `NVMC_WB_CFG) begin
                mode_q   <= wb_dat_i[1:0];
                rie_q    <= wb_dat_i[2];
                sp_chk_q <= wb_dat_i[`NVMC_CFG_SPCHK];
            end
        end
    end

    // sequencer; each link access is a one-cycle pulse; the poll, go, strobe and fetch accesses then take the gap and halt wait
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q    <= NVMC_H_IDLE;
            ret_q      <= NVMC_H_IDLE;
            op_rd_q    <= 1'b0;
            rd_data_q  <= 8'h00;
            io_addr_q  <= 6'h00;
            io_wdata_q <= 8'h00;
            io_we_q    <= 1'b0;
            io_re_q    <= 1'b0;
        end else begin
            io_we_q <= 1'b0;
            io_re_q <= 1'b0;
            unique case (state_q)
                NVMC_H_IDLE: begin
                    if (wr_en && idx == `NVMC_WB_CMD && (wb_dat_i[`NVMC_C_READ] || wb_dat_i[`NVMC_C_PROG])) begin
                        op_rd_q <= wb_dat_i[`NVMC_C_READ];
                        state_q <= NVMC_H_POLL;
                    end
                end
                NVMC_H_POLL: begin
                    io_addr_q <= `NVMC_IO_CTRL;
                    io_re_q   <= 1'b1;
                    ret_q     <= NVMC_H_CHK;
                    state_q   <= NVMC_H_GAP;
                end
                NVMC_H_CHK: begin
                    if (link.io_rdata[`NVMC_B_GO]) begin
                        state_q <= NVMC_H_POLL;
                    end else if (op_rd_q) begin
                        state_q <= NVMC_H_ADDR;
                    end else if (sp_chk_q && selfprog_active_i) begin
                        state_q <= NVMC_H_POLL;
                    end else begin
                        state_q <= NVMC_H_MODE;
                    end
                end
                NVMC_H_MODE: begin
                    io_addr_q  <= `NVMC_IO_CTRL;
                    io_wdata_q <= ctrl_base;
                    io_we_q    <= 1'b1;
                    state_q    <= NVMC_H_ADDR;
                end
                NVMC_H_ADDR: begin
                    io_addr_q  <= `NVMC_IO_ADDR;
                    io_wdata_q <= tgt_addr_q;
                    io_we_q    <= 1'b1;
                    state_q    <= op_rd_q ? NVMC_H_STROBE : NVMC_H_DATA;
                end
                NVMC_H_DATA: begin
                    io_addr_q  <= `NVMC_IO_DATA;
                    io_wdata_q <= tgt_data_q;
                    io_we_q    <= 1'b1;
                    state_q    <= NVMC_H_ARM;
                end
                NVMC_H_ARM: begin
                    io_addr_q  <= `NVMC_IO_CTRL;
                    io_wdata_q <= ctrl_base | 8'h04;
                    io_we_q    <= 1'b1;
                    state_q    <= NVMC_H_GO;
                end
                // go follows arm in the very next cycle, well inside the window
                NVMC_H_GO: begin
                    io_wdata_q <= ctrl_base | 8'h02;
                    io_we_q    <= 1'b1;
                    ret_q      <= NVMC_H_IDLE;
                    state_q    <= NVMC_H_GAP;
                end
                NVMC_H_STROBE: begin
                    io_addr_q  <= `NVMC_IO_CTRL;
                    io_wdata_q <= ctrl_base | 8'h01;
                    io_we_q    <= 1'b1;
                    ret_q      <= NVMC_H_FETCH;
                    state_q    <= NVMC_H_GAP;
                end
                NVMC_H_FETCH: begin
                    io_addr_q <= `NVMC_IO_DATA;
                    io_re_q   <= 1'b1;
                    ret_q     <= NVMC_H_TAKE;
                    state_q   <= NVMC_H_GAP;
                end
                NVMC_H_TAKE: begin
                    rd_data_q <= link.io_rdata;
                    state_q   <= NVMC_H_IDLE;
                end
                // the device sees the access in this cycle; halt can only show after it
                NVMC_H_GAP: begin
                    state_q <= NVMC_H_HOLD;
                end
                NVMC_H_HOLD: begin
                    if (!link.halt) begin
                        state_q <= ret_q;
                    end
                end
            endcase
        end
    end

    assign wb_ack_o      = ack_q;
    assign link.io_addr  = io_addr_q;
    assign link.io_wdata = io_wdata_q;
    assign link.io_we    = io_we_q;
    assign link.io_re    = io_re_q;

endmodule // nvmc_host

// ### nvmc_link_sva.sv
// concurrent checks on the i/o register link between host and device
`timescale 1ns/1ps
`include "nvmc_regs.svh"

module nvmc_link_sva (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // link signals
    input  wire logic [5:0] io_addr,
    input  wire logic [7:0] io_wdata,
    input  wire logic       io_we,
    input  wire logic       io_re,
    input  wire logic [7:0] io_rdata,
    input  wire logic       halt,
    input  wire logic       irq
);
    logic       ctl_wr;
    logic       rd_go;
    logic       pg_go;
    logic [2:0] arm_q;
    logic [1:0] mode_q;
    logic       rie_q;

    assign ctl_wr = io_we && io_addr == `NVMC_IO_CTRL;
    assign rd_go  = ctl_wr && io_wdata[`NVMC_B_RSTRB];
    assign pg_go  = ctl_wr && io_wdata[`NVMC_B_GO] && !io_wdata[`NVMC_B_RSTRB] && arm_q != 3'h0 && mode_q != 2'h3;

    // mirror of the arm window; an arm inside an open window does not restart it
    always_ff @(posedge clk_i) begin
        if (rst_i)
            arm_q <= 3'h0;
        else if (ctl_wr && io_wdata[`NVMC_B_ARM] && arm_q == 3'h0)
            arm_q <= `NVMC_ARM_CYCLES;
        else if (arm_q != 3'h0)
            arm_q <= arm_q - 3'h1;
    end

    // mode and enable as last written; the host never writes them while busy
    always_ff @(posedge clk_i) begin
        if (rst_i)
            mode_q <= 2'h0;
        else if (ctl_wr && !io_wdata[`NVMC_B_GO] && !io_wdata[`NVMC_B_RSTRB])
            mode_q <= io_wdata[`NVMC_B_MODE_HI:`NVMC_B_MODE_LO];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            rie_q <= 1'b0;
        else if (ctl_wr)
            rie_q <= io_wdata[`NVMC_B_RIE];
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_halt4;
        halt [*4] ##1 !halt;
    endsequence

    sequence s_halt2;
        halt [*2] ##1 !halt;
    endsequence

    a_read_halt_four: assert property (rd_go |=> s_halt4)
        else $error("read strobe halt length wrong");
    a_prog_halt_two: assert property (pg_go |=> s_halt2)
        else $error("program start halt length wrong");
    a_halt_has_cause: assert property ($rose(halt) |-> $past(rd_go || pg_go))
        else $error("halt without an accepted strobe or go");
    a_rsvd_no_prog: assert property (ctl_wr && io_wdata[`NVMC_B_GO] && mode_q == 2'h3 |=> !halt [*3])
        else $error("reserved mode started programming");
    a_busy_no_irq: assert property (pg_go |=> !irq [*8])
        else $error("ready interrupt while programming");
    a_irq_needs_rie: assert property (irq |-> rie_q)
        else $error("ready interrupt while disabled");
    a_no_io_halted: assert property (halt |-> !io_we && !io_re)
        else $error("link access while cpu halted");
    a_rdata_holds: assert property (!io_re |=> $stable(io_rdata))
        else $error("read data changed without a read");
    a_re_single: assert property (io_re |=> !io_re)
        else $error("read request longer than one cycle");
endmodule // nvmc_link_sva

// ### tb_byte_eeprom_controller.sv
// self-checking bench: host and device joined by the link, driven over wishbone
`timescale 1ns/1ps
`include "nvmc_regs.svh"

module tb_byte_eeprom_controller import nvmc_pkg::*;;
    localparam int AT = 20;
    localparam int ST = 10;
    logic        clk_i   = 1'b0;
    logic        rst_i   = 1'b1;
    logic        por_i   = 1'b1;
    logic        wb_cyc  = 1'b0;
    logic        wb_stb  = 1'b0;
    logic        wb_we   = 1'b0;
    logic [4:0]  wb_adr  = 5'h0;
    logic [31:0] wb_wdat = 32'h0;
    logic [3:0]  wb_sel  = 4'h0;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic        sp_act  = 1'b0;
    logic [31:0] q;
    int          n_errors   = 0;
    int          n_compared = 0;
    int          cycles     = 0;
    int          dur;
    int          mem_m [256];

    nvmc_link_if link_bus ();

    nvmc_device #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) nvmc_device_inst (
        .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .link(link_bus));
    nvmc_host nvmc_host_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .selfprog_active_i(sp_act), .link(link_bus));
    nvmc_link_sva nvmc_link_sva_inst (
        .clk_i(clk_i), .rst_i(rst_i), .io_addr(link_bus.io_addr), .io_wdata(link_bus.io_wdata),
        .io_we(link_bus.io_we), .io_re(link_bus.io_re), .io_rdata(link_bus.io_rdata),
        .halt(link_bus.halt), .irq(link_bus.irq));

    always #12.5 clk_i = ~clk_i;

    // hang guard, far above the few thousand cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [2:0] idx, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= w;
        wb_sel  <= 4'hF;
        wb_adr  <= {idx, 2'h0};
        wb_wdat <= d;
        // no local limit: a missing ack is caught by the cycle ceiling
        do begin
            @(posedge clk_i);
        end while (wb_ack !== 1'b1);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            wb(1'b0, `NVMC_WB_CMD, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 400);
        if (n == 400)
            n_errors++;
    endtask

    // c is {selfprog check, ready enable, mode}
    task automatic start(input int a, input int d, input logic [3:0] c);
        wb(1'b1, `NVMC_WB_ADDR, a);
        wb(1'b1, `NVMC_WB_WDATA, d);
        wb(1'b1, `NVMC_WB_CFG, {28'h0, c});
        wb(1'b1, `NVMC_WB_CMD, 32'h2);
        case (c[1:0])
            NVMC_MODE_ATOMIC: mem_m[a] = d;
            NVMC_MODE_ERASE: mem_m[a] = 255;
            NVMC_MODE_WRITE: if (mem_m[a] >= 0) mem_m[a] = mem_m[a] & d;
            default: ;
        endcase
    endtask

    // busy time is seen as the low stretch of the ready interrupt
    task automatic prog(input int a, input int d, input logic [3:0] c);
        int n;
        int t;
        t = (c[1:0] == 2'h0) ? AT * 5 : (c[1:0] == 2'h3) ? 0 : ST * 5;
        start(a, d, c);
        dur = 0;
        for (n = 0; n < 60 && link_bus.irq !== 1'b1; n++) @(posedge clk_i);
        for (n = 0; n < 60 && link_bus.irq !== 1'b0; n++) @(posedge clk_i);
        while (link_bus.irq === 1'b0 && dur < 400) begin
            @(posedge clk_i);
            dur++;
        end
        check(dur >= t - 6 && dur <= t + 6, 1'b1);
        wait_idle();
    endtask

    task automatic rd_check(input int a);
        wb(1'b1, `NVMC_WB_ADDR, a);
        wb(1'b1, `NVMC_WB_CMD, 32'h1);
        wait_idle();
        wb(1'b0, `NVMC_WB_RDATA, 32'h0);
        if (mem_m[a] >= 0)
            check(q, mem_m[a]);
    endtask

    initial begin
        void'($urandom(32'h7a7f));
        foreach (mem_m[i]) mem_m[i] = -1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        wb(1'b0, `NVMC_WB_CMD, 32'h0);
        check(q, 32'h0);
        wb(1'b0, 3'h7, 32'h0);
        check(q, 32'h0);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            prog(8'h5A, m * 8'h33 + 1, 4'h4 | m);
            rd_check(8'h5A);
        end
        prog(8'h5A, 8'h0F, 4'h6);
        rd_check(8'h5A);
        $display("test modes done");
        prog(8'h00, $urandom & 8'hFF, 4'h4);
        prog(8'hFF, $urandom & 8'hFF, 4'h4);
        rd_check(8'h00);
        rd_check(8'hFF);
        for (int i = 0; i < 3; i++) begin
            prog(8'h60 + i, $urandom & 8'hFF, 4'h4);
            rd_check(8'h60 + i);
        end
        wb(1'b0, `NVMC_WB_CMD, 32'h0);
        check(q[2:0], 3'h2);
        $display("test random done");
        start(8'h30, 8'h11, 4'h4);
        wb(1'b1, `NVMC_WB_ADDR, 32'h31);
        wb(1'b1, `NVMC_WB_WDATA, 32'h22);
        wb(1'b1, `NVMC_WB_CMD, 32'h2);
        wait_idle();
        rd_check(8'h30);
        $display("test busy refusal done");
        start(8'h40, $urandom & 8'hFF, 4'h4);
        repeat (60) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_check(8'h40);
        wb(1'b0, `NVMC_WB_CMD, 32'h0);
        check(q[1], 1'b0);
        $display("test reset while busy done");
        sp_act <= 1'b1;
        start(8'h50, 8'hC3, 4'hC);
        repeat (50) @(posedge clk_i);
        wb(1'b0, `NVMC_WB_CMD, 32'h0);
        check(q[0], 1'b1);
        sp_act <= 1'b0;
        wait_idle();
        rd_check(8'h50);
        $display("test selfprog wait done");
        tally_and_finish();
    end
endmodule // tb_byte_eeprom_controller
